// File: src/bwwl_regs.svh
// constants for the burst sequencing and wait timing block
`ifndef BWWL_REGS_SVH
`define BWWL_REGS_SVH
`define BWWL_ADDR_REG_CFG 12'h000
`define BWWL_ADDR_REG_CTRL 12'h004
`define BWWL_ADDR_REG_STAT 12'h008
`define BWWL_ADDR_REG_ADDR 12'h00C
`define BWWL_CFG_RESET 16'h1D1F
`define BWWL_BL_LSB 0
`define BWWL_WRAP_BIT 3
`define BWWL_DRV_LSB 4
`define BWWL_WCFG_BIT 8
`define BWWL_WPOL_BIT 10
`define BWWL_LAT_LSB 11
`define BWWL_CODE_BL4 3'h1
`define BWWL_CODE_BL8 3'h2
`define BWWL_CODE_SIXTEEN_WORD_BURST 3'h3
`define BWWL_CODE_THIRTYTWO_WORD_BURST 3'h4
`define BWWL_CODE_CONT 3'h7
`define BWWL_ROW_LAST 8'hFF
`define BWWL_LAT_MIN 3'h2
`define BWWL_LAT_MAX 3'h6
`endif

// File: src/bwwl_pkg.sv
// types for the burst sequencing and wait timing block
package bwwl_pkg;
    typedef enum logic [3:0] {
        BWWL_IDLE = 4'b0001,
        BWWL_LAT = 4'b0010,
        BWWL_DATA = 4'b0100,
        BWWL_DONE = 4'b1000
    } bwwl_state_t;
    typedef enum logic [1:0] {
        BWWL_DRV_FULL = 2'h0,
        BWWL_DRV_HALF = 2'h1,
        BWWL_DRV_QUARTER = 2'h2,
        BWWL_DRV_RSVD = 2'h3
    } bwwl_drive_t;
endpackage

// File: src/bwwl_addr_step.sv
// burst address stepper: wrap inside the group or run linearly to row end
`timescale 1ns/100ps
`include "bwwl_regs.svh"
module bwwl_addr_step (
    // current word and settings
    input wire logic [7:0] cur,
    input wire logic [2:0] blen,
    input wire logic wrap,
    // stepped word and end of row flag
    output logic [7:0] nxt,
    output logic row_end
);
    logic [7:0] mask;
    logic [7:0] inc;
    // low-bit mask that covers the burst group
    always_comb begin
        unique case (blen)
            `BWWL_CODE_BL4: mask = 8'h03;
            `BWWL_CODE_BL8: mask = 8'h07;
            `BWWL_CODE_SIXTEEN_WORD_BURST: mask = 8'h0F;
            `BWWL_CODE_THIRTYTWO_WORD_BURST: mask = 8'h1F;
            default: mask = 8'h00;
        endcase
    end
    // continuous bursts never wrap
    always_comb begin
        inc = cur + 8'h01;
        if (wrap && (mask != 8'h00)) begin
            nxt = (cur & ~mask) | (inc & mask);
        end else begin
            nxt = inc;
        end
        // a continuous burst stops at row end even with the wrap bit set
        row_end = (!wrap || (mask == 8'h00)) && (cur == `BWWL_ROW_LAST);
    end
endmodule

// File: src/bwwl_top.sv
// burst sequencing, wait timing and latency core with an apb register port
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/100ps
`include "bwwl_regs.svh"
module bwwl_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // burst side
    output logic wait_out,
    output logic data_valid,
    output logic [7:0] word_addr,
    output bwwl_pkg::bwwl_drive_t drive_sel
);
    import bwwl_pkg::*;
    logic [15:0] bus_config_reg, next_cfg;
    bwwl_state_t state, next_state;
    logic [2:0] cnt, next_cnt;
    logic [7:0] word, next_word;
    logic [5:0] left, next_left;
    logic busy_w, next_wait, next_valid, next_ready, next_err;
    logic [31:0] next_rdata;
    logic [7:0] step_word;
    logic step_end;
    logic acc, wr, start, stop;
    logic [2:0] blen;
    logic [2:0] lat;
    logic [5:0] blen_words;
    logic wait_early;

    assign blen = bus_config_reg[`BWWL_BL_LSB +: 3];
    assign lat = bus_config_reg[`BWWL_LAT_LSB +: 3];
    assign acc = psel && penable && !pready;
    assign wr = acc && pwrite;
    assign wait_early = bus_config_reg[`BWWL_WCFG_BIT];

    // words in a fixed burst, zero for continuous
    function automatic logic [5:0] words_of(input logic [2:0] code);
        unique case (code)
            `BWWL_CODE_BL4: words_of = 6'h04;
            `BWWL_CODE_BL8: words_of = 6'h08;
            `BWWL_CODE_SIXTEEN_WORD_BURST: words_of = 6'h10;
            `BWWL_CODE_THIRTYTWO_WORD_BURST: words_of = 6'h20;
            default: words_of = 6'h00;
        endcase
    endfunction
    assign blen_words = words_of(blen);

    bwwl_addr_step u_step (
        .cur(word),
        .blen(blen),
        .wrap(!bus_config_reg[`BWWL_WRAP_BIT]),
        .nxt(step_word),
        .row_end(step_end)
    );

    // apb register file and command strobes
    always_comb begin
        next_cfg = bus_config_reg;
        next_rdata = prdata;
        next_ready = acc;
        next_err = 1'b0;
        start = 1'b0;
        stop = 1'b0;
        if (acc) begin
            next_rdata = 32'h0000_0000;
            unique case (paddr)
                `BWWL_ADDR_REG_CFG: begin
                    if (pwrite) begin
                        next_cfg = pwdata[15:0];
                    end
                    next_rdata = {16'h0000, bus_config_reg};
                end
                `BWWL_ADDR_REG_CTRL: begin
                    start = wr && pwdata[0];
                    stop = wr && pwdata[1];
                end
                `BWWL_ADDR_REG_STAT: next_rdata = {24'h0, 4'(state), 1'b0, cnt};
                `BWWL_ADDR_REG_ADDR: next_rdata = {24'h0, word};
                default: next_err = 1'b1;
            endcase
        end
    end

    // latency count then data phase
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_word = word;
        next_left = left;
        busy_w = 1'b1;
        unique case (state)
            BWWL_IDLE: begin
                busy_w = 1'b0;
                if (start && lat >= `BWWL_LAT_MIN && lat <= `BWWL_LAT_MAX) begin
                    next_state = BWWL_LAT;
                    next_cnt = lat;
                    next_word = pwdata[15:8];
                    next_left = blen_words;
                end
            end
            BWWL_LAT: begin
                if (cnt == 3'h0) begin
                    next_state = BWWL_DATA;
                end else begin
                    next_cnt = cnt - 3'h1;
                end
            end
            BWWL_DATA: begin
                busy_w = 1'b0;
                next_word = step_word;
                if (left != 6'h00) begin
                    next_left = left - 6'h01;
                end
                if (step_end || left == 6'h01 || stop) begin
                    next_state = BWWL_DONE;
                end
            end
            BWWL_DONE: next_state = BWWL_IDLE;
        endcase
        if (stop && state != BWWL_DATA) begin
            next_state = BWWL_IDLE;
        end
    end

    // wait leads data by one clock or releases on the same clock as data
    always_comb begin
        next_valid = (state == BWWL_DATA);
        if (wait_early) begin
            next_wait = (next_state != BWWL_DATA) && (next_state != BWWL_IDLE);
        end else begin
            next_wait = busy_w && (state != BWWL_IDLE);
        end
        next_wait = bus_config_reg[`BWWL_WPOL_BIT] ? next_wait : !next_wait;
    end

    // register stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_config_reg <= `BWWL_CFG_RESET;
            state <= BWWL_IDLE;
            cnt <= 3'h0;
            word <= 8'h00;
            left <= 6'h00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            wait_out <= 1'b0;
            data_valid <= 1'b0;
            word_addr <= 8'h00;
            drive_sel <= BWWL_DRV_HALF;
        end else begin
            bus_config_reg <= next_cfg;
            state <= next_state;
            cnt <= next_cnt;
            word <= next_word;
            left <= next_left;
            prdata <= next_rdata;
            pready <= next_ready;
            pslverr <= next_err;
            wait_out <= next_wait;
            data_valid <= next_valid;
            word_addr <= word;
            drive_sel <= bwwl_drive_t'(bus_config_reg[`BWWL_DRV_LSB +: 2]);
        end
    end

    // checks
    lat_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(state == BWWL_LAT)) |-> (state == BWWL_LAT) [*3])
        else $error("latency shorter than three clocks");
    wait_lead_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wait_early && $rose(state == BWWL_DATA))
        |-> ((wait_out != bus_config_reg[`BWWL_WPOL_BIT]) && !data_valid) ##1 data_valid)
        else $error("data did not follow wait lead");
    wait_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!wait_early && $rose(state == BWWL_DATA)) |-> (wait_out == bus_config_reg[`BWWL_WPOL_BIT])
        ##1 ((wait_out != bus_config_reg[`BWWL_WPOL_BIT]) && data_valid))
        else $error("data not valid on edge after wait release");
    wrap_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == BWWL_DATA && !bus_config_reg[`BWWL_WRAP_BIT] && blen == `BWWL_CODE_BL4)
        |-> (next_word[7:2] == word[7:2]))
        else $error("wrap changed upper bits");
    row_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == BWWL_DATA && bus_config_reg[`BWWL_WRAP_BIT] && word == 8'hFF)
        |=> (state == BWWL_DONE))
        else $error("linear burst ran past row end");
    drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (drive_sel == $past(bus_config_reg[5:4])))
        else $error("drive decode mismatch");
    cfg_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        (acc) |=> pready)
        else $error("apb not answered");
    burst4_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(state == BWWL_DATA) && left == 6'h04 && !stop) |-> (state == BWWL_DATA) [*4])
        else $error("four word burst cut short");
    idle_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == BWWL_IDLE && $past(state) == BWWL_IDLE) |=> !data_valid)
        else $error("data valid while idle");
endmodule

// File: testbench/bwwl_ctrl_model.sv
// memory controller model that watches wait and collects words
`timescale 1ns/100ps
module bwwl_ctrl_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // burst side of the block and the asserted wait level
    input wire logic wait_out,
    input wire logic data_valid,
    input wire logic [7:0] word_addr,
    input wire logic pol
);
    logic [7:0] words[$];
    int cyc = 0;
    int t_dea = -1;
    int t_dv = -1;
    logic last_wait = 0;
    // watch wait for the end of the delay and take each valid word
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (!presetn) begin
            words.delete();
        end
        if (last_wait === pol && wait_out !== pol && t_dea < 0) begin
            t_dea = cyc;
        end
        if (data_valid === 1'b1) begin
            if (words.size() == 0) begin
                t_dv = cyc;
            end
            words.push_back(word_addr);
        end
        last_wait = wait_out;
    end
endmodule

// File: testbench/tb.sv
// self-checking bench for the burst sequencing and wait timing block
`timescale 1ns/100ps
`include "bwwl_regs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
    import bwwl_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mpol = 1, serr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, wait_out, data_valid;
    logic [7:0] word_addr;
    bwwl_drive_t drive_sel;
    int n_errors = 0, comparisons = 0, tick = 0, t0, g1, t_base;
    always #5 pclk = ~pclk;
    bwwl_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wait_out(wait_out), .data_valid(data_valid),
        .word_addr(word_addr), .drive_sel(drive_sel));
    bwwl_ctrl_model model_u (.pclk(pclk), .presetn(presetn), .wait_out(wait_out),
        .data_valid(data_valid), .word_addr(word_addr), .pol(mpol));
    // closing report
    task give_verdict;
        $display("counts: %0d compared, %0d mismatched", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // one apb transfer, held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
        `CHK("pready", 1'b1, pready)
        rd = prdata;
        serr = pslverr;
        psel <= 0; penable <= 0;
    endtask
    function logic [15:0] cfg(input logic [2:0] lat, input logic pl, wc, nw,
        input logic [2:0] bl, input logic [1:0] dv);
        return {2'h0, lat, pl, 1'b0, wc, 2'h0, dv, nw, bl};
    endfunction
    // set up and start a burst, then compare the collected words
    task burst(input logic [15:0] c, input logic [7:0] st, input int len);
        int n;
        logic [7:0] m;
        logic lin;
        m = 8'(len - 1);
        // continuous bursts never wrap, so they run linearly too
        lin = c[3] || (c[2:0] == `BWWL_CODE_CONT);
        n = lin ? ((256 - st < len) ? 256 - st : len) : len;
        apb(1, `BWWL_ADDR_REG_CFG, {16'h0, c});
        @(negedge pclk);
        model_u.words.delete(); model_u.t_dea = -1; model_u.t_dv = -1;
        apb(1, `BWWL_ADDR_REG_CTRL, {16'h0, st, 8'h01});
        // model cycle one clock after the start was taken
        @(negedge pclk);
        t0 = model_u.cyc;
        rd = 0;
        for (int k = 0; k < 100 && rd[4] !== 1'b1; k++) apb(0, `BWWL_ADDR_REG_STAT, 0);
        repeat (3) @(posedge pclk);
        `CHK("words", n, model_u.words.size())
        for (int i = 0; i < n && i < model_u.words.size(); i++)
            `CHK("word", lin ? 8'(st + i) : (st & ~m) | (8'(st + i) & m), model_u.words[i])
    endtask
    // cut a hang short
    always @(posedge pclk) begin
        tick++;
        if (tick == 8000) begin n_errors++; give_verdict; end
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        apb(0, `BWWL_ADDR_REG_CFG, 0);
        `CHK("cfg", 32'h0000_1D1F, rd)
        `CHK("drive", BWWL_DRV_HALF, drive_sel)
        `CHK("wait", 1'b0, wait_out)
        for (int d = 0; d < 4; d++) begin
            apb(1, `BWWL_ADDR_REG_CFG, {16'h0, cfg(3'h3, 1, 1, 1, 3'h7, 2'(d))});
            repeat (2) @(posedge pclk);
            `CHK("drive", bwwl_drive_t'(d), drive_sel)
        end
        $display("test reset and drive done");
        burst(cfg(3'h3, 1, 1, 0, 3'h1, 2'h1), 8'd6, 4);
        for (int k = 1; k < 5; k++) begin
            burst(cfg(3'h3, 1, 1, 0, 3'(k), 2'h1), 8'd14, 4 << (k - 1));
            burst(cfg(3'h3, 1, 1, 1, 3'(k), 2'h1), 8'd250, 4 << (k - 1));
        end
        burst(cfg(3'h3, 1, 1, 1, 3'h7, 2'h1), 8'd250, 256);
        burst(cfg(3'h3, 1, 1, 0, 3'h7, 2'h1), 8'd250, 256);
        // continuous burst cut by a stop command
        apb(1, `BWWL_ADDR_REG_CFG, {16'h0, cfg(3'h3, 1, 1, 1, 3'h7, 2'h1)});
        @(negedge pclk);
        model_u.words.delete();
        apb(1, `BWWL_ADDR_REG_CTRL, 32'h0000_0001);
        repeat (4) apb(0, `BWWL_ADDR_REG_STAT, 0);
        apb(1, `BWWL_ADDR_REG_CTRL, 32'h0000_0002);
        apb(0, `BWWL_ADDR_REG_STAT, 0);
        `CHK("stop idle", 1'b1, rd[4])
        repeat (3) @(posedge pclk);
        `CHK("stop words", 1'b1, model_u.words.size() > 0 && model_u.words.size() < 256)
        `CHK("stop last", 8'(model_u.words.size() - 1), model_u.words[model_u.words.size() - 1])
        $display("test sequences done");
        for (int l = 2; l < 7; l++) begin
            burst(cfg(3'(l), 1, 1, 0, 3'h1, 2'h1), 8'd0, 4);
            if (l == 2) t_base = model_u.t_dv - t0;
            `CHK("latency", l - 2, model_u.t_dv - t0 - t_base)
            // code plus one clocks, one more for the valid register, one more for the late sample, less the clock t0 trails the start
            `CHK("latency abs", l + 2, model_u.t_dv - t0)
        end
        burst(cfg(3'h7, 1, 1, 0, 3'h1, 2'h1), 8'd0, 0);
        $display("test latency done");
        burst(cfg(3'h3, 1, 1, 0, 3'h1, 2'h1), 8'd0, 4);
        g1 = model_u.t_dv - model_u.t_dea;
        burst(cfg(3'h3, 1, 0, 0, 3'h1, 2'h1), 8'd0, 4);
        `CHK("wait lead", 1, g1 - (model_u.t_dv - model_u.t_dea))
        mpol <= 0;
        apb(1, `BWWL_ADDR_REG_CFG, {16'h0, cfg(3'h3, 0, 1, 0, 3'h1, 2'h1)});
        repeat (2) @(posedge pclk);
        `CHK("wait idle", 1'b1, wait_out)
        burst(cfg(3'h3, 0, 1, 0, 3'h1, 2'h1), 8'd7, 4);
        `CHK("wait lead low", 1, model_u.t_dv - model_u.t_dea)
        apb(0, 12'h010, 0);
        `CHK("slverr", 1'b1, serr)
        `CHK("rdata", 32'h0, rd)
        $display("test wait and bus done");
        give_verdict;
    end
endmodule
